// ==== rtl/ncopa_pkg.sv ====
// Package of register map, widths and reset values for the phase path.
package ncopa_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ACC_W   = 32;
    localparam int IDX_W   = 16;
    localparam int BYTE_W  = 8;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 12;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_FREQ0  = 8'h08;
    localparam logic [7:0] IDX_FREQ1  = 8'h09;
    localparam logic [7:0] IDX_FREQ2  = 8'h0a;
    localparam logic [7:0] IDX_FREQ3  = 8'h0b;
    localparam logic [7:0] IDX_PHASE_LO = 8'h07;
    localparam logic [7:0] IDX_PHASE_HI = 8'h06;
    localparam logic [7:0] IDX_ACC_STAT = 8'h20;
    localparam int         IDX_LSB    = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [ACC_W-1:0]  ACC_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ZERO_RD  = 32'h0000_0000;

endpackage : ncopa_pkg

// ==== rtl/ncopa_cfg_if.sv ====
// Interface carrying the programmed frequency word and phase offset.
`timescale 1ns/100ps
interface ncopa_cfg_if;
    import ncopa_pkg::*;
    logic [ACC_W-1:0] freq_word;
    logic [IDX_W-1:0] phase_shift;

    modport regs (output freq_word, output phase_shift);
    modport core (input freq_word, input phase_shift);
endinterface : ncopa_cfg_if

// ==== rtl/ncopa_accum.sv ====
// Phase accumulator core with offset addition and index extraction.
`timescale 1ns/100ps
module ncopa_accum (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    ncopa_cfg_if.core                      cfg,
    output logic [ncopa_pkg::ACC_W-1:0]    acc_q,
    output logic [ncopa_pkg::IDX_W-1:0]    index_q
);
    import ncopa_pkg::*;

    logic [ACC_W-1:0] acc_d;
    logic [IDX_W-1:0] index_d;

    // Adding the raw word modulo 2^32 gives signed behaviour for free:
    // a negative word is a large unsigned step that wraps backwards.
    assign acc_d = acc_q + cfg.freq_word;

    // The offset goes on the upper bits of the new phase only.
    assign index_d = acc_d[ACC_W-1 -: IDX_W] + cfg.phase_shift;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_q <= '0;
        end else begin
            index_q <= index_d;
        end
    end

endmodule // ncopa_accum

// ==== rtl/ncopa_top.sv ====
// Top of the oscillator phase path with its APB register slave.
//
// Overview of operation
// - Frequency word accumulates into phase accumulator.
// - Frequency word is signed two's complement.
// - One word step equals rate over 2^32.
// - Phase offset added right before lookup.
// - Upper 16 accumulator bits plus offset form lookup index.
// - Top frequency byte at index 0x0B, resets 0.
`timescale 1ns/100ps
module ncopa_top (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ncopa_pkg::ADDR_W-1:0] paddr,
    input  wire logic [ncopa_pkg::DATA_W-1:0] pwdata,
    output logic      [ncopa_pkg::DATA_W-1:0] prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic      [ncopa_pkg::IDX_W-1:0]  phase_index
);
    import ncopa_pkg::*;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [BYTE_W-1:0] freq_byte0_reg_q;
    logic [BYTE_W-1:0] freq_byte1_reg_q;
    logic [BYTE_W-1:0] freq_byte2_reg_q;
    logic [BYTE_W-1:0] freq_byte3_reg_q;
    logic [BYTE_W-1:0] phase_lo_q;
    logic [BYTE_W-1:0] phase_hi_q;
    logic [ACC_W-1:0]  acc_w;
    logic [IDX_W-1:0]  index_w;
    logic              setup;
    logic              wr_en;
    logic [7:0]        reg_idx;
    logic              hit;
    logic [DATA_W-1:0] rd_d;
    // Per-register write strobes.
    logic              wr_freq0;
    logic              wr_freq1;
    logic              wr_freq2;
    logic              wr_freq3;
    logic              wr_phase_lo;
    logic              wr_phase_hi;

    ncopa_cfg_if cfg ();

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Each byte register sits on its own aligned word, so the index is
    // taken above the byte-select bits of the address.
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
        return a[IDX_LSB +: 8];
    endfunction

    // Only these indices answer without an error.
    function automatic logic is_mapped(input logic [7:0] ix);
        return (ix == IDX_FREQ0)    ||
               (ix == IDX_FREQ1)    ||
               (ix == IDX_FREQ2)    ||
               (ix == IDX_FREQ3)    ||
               (ix == IDX_PHASE_LO) ||
               (ix == IDX_PHASE_HI) ||
               (ix == IDX_ACC_STAT);
    endfunction

    // Decoded once per register so each flop has a plain enable.
    function automatic logic strobe(input logic en, input logic [7:0] ix,
                                    input logic [7:0] want);
        return en && (ix == want);
    endfunction

    // Zero-wait slave: the access phase completes in its first cycle.
    assign setup   = psel && !penable;
    assign reg_idx = word_index(paddr);
    assign hit     = (paddr[IDX_LSB-1:0] == '0) && is_mapped(reg_idx);
    assign wr_en   = psel && penable && pready && pwrite && hit;

    // ------------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------------
    // A write lands only at the edge that ends the access phase, so a
    // refused address never disturbs a register.
    assign wr_freq0    = strobe(wr_en, reg_idx, IDX_FREQ0);
    assign wr_freq1    = strobe(wr_en, reg_idx, IDX_FREQ1);
    assign wr_freq2    = strobe(wr_en, reg_idx, IDX_FREQ2);
    assign wr_freq3    = strobe(wr_en, reg_idx, IDX_FREQ3);
    assign wr_phase_lo = strobe(wr_en, reg_idx, IDX_PHASE_LO);
    assign wr_phase_hi = strobe(wr_en, reg_idx, IDX_PHASE_HI);

    // ------------------------------------------------------------------
    // Registers, one process each
    // ------------------------------------------------------------------
    // All registers come out of reset as zero bytes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_byte0_reg_q <= BYTE_RST;
        end else if (wr_freq0) begin
            freq_byte0_reg_q <= pwdata[BYTE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_byte1_reg_q <= BYTE_RST;
        end else if (wr_freq1) begin
            freq_byte1_reg_q <= pwdata[BYTE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_byte2_reg_q <= BYTE_RST;
        end else if (wr_freq2) begin
            freq_byte2_reg_q <= pwdata[BYTE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_byte3_reg_q <= BYTE_RST;
        end else if (wr_freq3) begin
            freq_byte3_reg_q <= pwdata[BYTE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_lo_q <= BYTE_RST;
        end else if (wr_phase_lo) begin
            phase_lo_q <= pwdata[BYTE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_hi_q <= BYTE_RST;
        end else if (wr_phase_hi) begin
            phase_hi_q <= pwdata[BYTE_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Configuration handed to the phase path
    // ------------------------------------------------------------------
    // Bytes take effect one at a time, so a word rewritten byte by byte
    // runs briefly at the in-between frequencies; software that cares
    // writes the bytes in an order that keeps those steps harmless.
    assign cfg.freq_word   = {freq_byte3_reg_q, freq_byte2_reg_q,
                              freq_byte1_reg_q, freq_byte0_reg_q};
    assign cfg.phase_shift = {phase_hi_q, phase_lo_q};

    // ------------------------------------------------------------------
    // Phase path
    // ------------------------------------------------------------------
    // The accumulator sits in its own module so that its adder can be
    // retimed without touching the register slave.
    ncopa_accum u_accum (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg.core),
        .acc_q   (acc_w),
        .index_q (index_w)
    );

    assign phase_index = index_w;

    // ------------------------------------------------------------------
    // Read path and handshake
    // ------------------------------------------------------------------
    // The status word is a live view: a read returns the accumulator as
    // it stood at the setup edge, not at the end of the access.
    always_comb begin
        rd_d = ZERO_RD;
        unique case (reg_idx)
            IDX_FREQ0:    rd_d[BYTE_W-1:0] = freq_byte0_reg_q;
            IDX_FREQ1:    rd_d[BYTE_W-1:0] = freq_byte1_reg_q;
            IDX_FREQ2:    rd_d[BYTE_W-1:0] = freq_byte2_reg_q;
            IDX_FREQ3:    rd_d[BYTE_W-1:0] = freq_byte3_reg_q;
            IDX_PHASE_LO: rd_d[BYTE_W-1:0] = phase_lo_q;
            IDX_PHASE_HI: rd_d[BYTE_W-1:0] = phase_hi_q;
            IDX_ACC_STAT: rd_d             = acc_w;
            default:      rd_d             = ZERO_RD;
        endcase
    end

    // Answers are registered at the setup edge so every output is a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Read data stands only in the access cycle and is zero otherwise,
    // so a stale value can never be mistaken for a fresh answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ZERO_RD;
        end else if (setup && !pwrite && hit) begin
            prdata <= rd_d;
        end else begin
            prdata <= ZERO_RD;
        end
    end

    // A refused address still completes, so a master never hangs on it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !hit;
        end
    end

endmodule // ncopa_top

// ==== test/ncopa_props.sv ====
// Checker of the port behaviour of the oscillator phase path.
`timescale 1ns/100ps
module ncopa_props
    import ncopa_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic [IDX_W-1:0]  phase_index
);
    logic [7:0]  r_q [16];
    logic [31:0] a_q;
    logic [15:0] p_q;
    logic [1:0]  sc_q;
    wire         wr = psel & penable & pready & pwrite & ~pslverr;
    wire  [31:0] w = {r_q[11], r_q[10], r_q[9], r_q[8]};
    wire  [15:0] o = {r_q[6], r_q[7]};
    // Shadow of the registers and accumulator, rebuilt from bus writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{default: '0};
            {a_q, p_q, sc_q} <= '0;
        end else begin
            a_q <= a_q + w;
            p_q <= 16'((a_q + w) >> 16) + o;
            sc_q <= wr ? 2'h0 : sc_q + {1'b0, sc_q != 2'h3};
            if (wr) r_q[paddr[5:2]] <= pwdata[7:0];
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_idx; phase_index == p_q; endproperty
    a_idx: assert property (p_idx) else $error("index off");
    property p_step; sc_q == 2'h3 && w[15:0] == 16'h0 |->
        16'(phase_index - $past(phase_index)) == w[31:16]; endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_rd; pready && !pwrite && !pslverr && paddr[9:2] == IDX_FREQ3
        |-> prdata == {24'h0, r_q[11]}; endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_err; pready && paddr[9:2] == IDX_FREQ3 |-> !pslverr; endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_zero; !pready |-> prdata == '0; endproperty
    a_zero: assert property (p_zero) else $error("stray data");
    c_neg: cover property (sc_q == 2'h3 && w[31]);
    c_wr3: cover property (wr && paddr[9:2] == IDX_FREQ3);
    c_err: cover property (pready && pslverr);
endmodule // ncopa_props
bind ncopa_top ncopa_props u_props (.*);

// ==== test/ncopa_top_tb_top.sv ====
// Self-checking bench of the oscillator phase path.
`timescale 1ns/100ps
module ncopa_top_tb_top;
    import ncopa_pkg::*;
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic              pwrite = 0, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic [IDX_W-1:0]  phase_index, p0;
    logic [7:0]        ids [6] = '{IDX_PHASE_HI, IDX_PHASE_LO, IDX_FREQ0,
                                   IDX_FREQ1, IDX_FREQ2, IDX_FREQ3};
    int                error_cnt = 0, n_checks = 0;
    ncopa_top dut (.*);
    initial forever #5 pclk = ~pclk;
    task automatic chk(input logic [32:0] s, e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h vs %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, logic [7:0] ix, logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'h0, ix, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_regs;
        foreach (ids[i]) begin
            bus(1'b0, ids[i], '0);
            chk(rd, '0);
            bus(1'b1, ids[i], {24'hffffff, 8'ha0 + 8'(i)});
            bus(1'b0, ids[i], '0);
            chk({rd, er}, {8'h0, 8'ha0 + 8'(i), 1'b0});
        end
        bus(1'b0, 8'h30, '0);
        chk({rd, er}, 33'h1);
    endtask
    task automatic word(input logic [31:0] v);
        for (int i = 0; i < 4; i++) bus(1'b1, IDX_FREQ0 + 8'(i), v[8*i +: 8]);
    endtask
    task automatic rate(input logic [31:0] v, int n, logic [15:0] d);
        word(v);
        repeat (3) @(posedge pclk);
        p0 = phase_index;
        repeat (n) @(posedge pclk);
        chk(16'(phase_index - p0), d);
    endtask
    task automatic t_rate;
        rate(32'h0001_0000, 1, 16'h0001);
        rate(32'hffff_0000, 1, 16'hffff);
        rate(32'h0000_8000, 4, 16'h0002);
        rate(32'h8000_0000, 2, 16'h0000);
    endtask
    task automatic t_off;
        rate(32'h0, 2, 16'h0);
        bus(1'b1, IDX_PHASE_HI, 32'h12);
        bus(1'b1, IDX_PHASE_LO, 32'h34);
        @(posedge pclk);
        chk(16'(phase_index - p0), 16'(16'h1234 - 16'ha0a1));
        bus(1'b0, IDX_ACC_STAT, '0);
        chk(phase_index, 16'(rd[31:16] + 16'h1234));
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_rate;
        t_off;
        print_verdict;
    end
    initial begin
        #50us;
        error_cnt++;
        print_verdict;
    end
endmodule // ncopa_top_tb_top
